// *** tb/line_receiver_model.sv ***
// far-end receiver that samples the line at mid-bit with a fixed bit time
`timescale 1ns/100ps
module line_receiver_model (
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic        line_i,
  input  wire logic [15:0] bit_clks_i,
  input  wire logic [3:0]  nbits_i,
  output logic             first_stop_o,
  output logic             stop_strobe_o
);
  int word_q[$]; // bits after start, up to the first stop
  int gap_q[$];  // clocks between start edges
  int cyc = 0;   // free clock count
  int last = 0;  // clock of the previous start edge
  int w;         // frame being gathered
  always @(posedge clk_i) cyc <= cyc + 1;
  initial begin
    first_stop_o = 1'b1;
    stop_strobe_o = 1'b0;
    forever begin
      @(posedge clk_i);
      // a low line while idle is a start bit
      if (en_i && line_i === 1'b0) begin
        gap_q.push_back(cyc - last);
        last = cyc;
        repeat (bit_clks_i / 2) @(posedge clk_i);
        w = 0;
        for (int i = 0; i < nbits_i; i++) begin
          repeat (bit_clks_i) @(posedge clk_i);
          w[i] = line_i;
        end
        word_q.push_back(w);
        // only the first stop is judged, a second one is ignored
        first_stop_o <= line_i;
        stop_strobe_o <= 1'b1;
        @(posedge clk_i);
        stop_strobe_o <= 1'b0;
      end
    end
  end
endmodule : line_receiver_model

// *** tb/usart_frame_transmitter_bench.sv ***
// self-checking bench for the frame transmitter against a far-end receiver
`timescale 1ns/100ps
module usart_frame_transmitter_bench;
  import usart_tx_pkg::*;
  logic clk_i, reset_i, stop_bits_sel_i, double_speed_bit_i, sync_mode_i, sync_master_i;
  logic clock_polarity_i, transmitter_on_i, tx_ninth_bit_i, data_write_i, tx_complete_clear_i;
  logic sync_clock_pin_i, rx_first_stop_i, rx_stop_strobe_i, penable;
  logic data_ready_o, tx_buffer_empty_flag_o, tx_complete_flag_o, frame_error_flag_o;
  logic serial_out_pin_o, serial_out_oe_o, sync_clock_pin_o, sync_clock_oe_o;
  char_size_t  char_size_sel_i;
  logic [1:0]  parity_mode_sel_i;
  logic [11:0] baud_divisor_reg_i;
  logic [7:0]  data_buffer_reg_i;
  logic [31:0] seed = 32'h30F40D14; // xorshift state
  int n_fail = 0;
  int total_checks = 0;
  int bc; // clocks per bit
  int nb; // sampled bits after start
  int exp_q[$]; // expected frames
  usart_frame_transmitter usart_frame_transmitter_i (.*);
  line_receiver_model line_receiver_model_i (.clk_i(clk_i), .en_i(penable),
    .line_i(serial_out_pin_o | !serial_out_oe_o), .bit_clks_i(16'(bc)), .nbits_i(4'(nb)),
    .first_stop_o(rx_first_stop_i), .stop_strobe_o(rx_stop_strobe_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int nd(); // data bits of the size code
    if (char_size_sel_i == 3'h7) return 9;
    if (char_size_sel_i > 3'h3) return 8; // reserved codes act as eight
    return char_size_sel_i + 5;
  endfunction : nd
  function automatic int frame(input int d); // line bits after start
    int n;
    int m;
    int p;
    n = nd();
    m = d & ((1 << n) - 1);
    p = parity_mode_sel_i[1];
    return m | ((((^m) ^ parity_mode_sel_i[0]) & p) << n) | (1 << (n + p));
  endfunction : frame
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // bounded wait for the pin owner flag
  task automatic wait_oe(input logic v);
    for (int k = 0; k < 60000 && serial_out_oe_o !== v; k++) @(negedge clk_i);
    check(serial_out_oe_o, v);
  endtask : wait_oe
  // one format: fill while disabled, enable, disable at once, let it drain
  task automatic round(input int r, input int cnt);
    int d;
    int g;
    @(negedge clk_i);
    // format and clocking change only while drained and disabled
    char_size_sel_i = r[2:0];
    parity_mode_sel_i = 2'(r / 3);
    stop_bits_sel_i = r[1] ^ r[3];
    // the last two rounds run as synchronous master, both polarities
    sync_mode_i = (r >= 10);
    sync_master_i = 1'b1;
    clock_polarity_i = r[0];
    // master needs at least eight clocks per bit for mid-bit sampling
    baud_divisor_reg_i = 12'(rnd() % 3 + (sync_mode_i ? 3 : 0));
    double_speed_bit_i = 1'(rnd());
    if (sync_mode_i) bc = 2 * (baud_divisor_reg_i + 1);
    else bc = (double_speed_bit_i ? 8 : 16) * (baud_divisor_reg_i + 1);
    nb = nd() + parity_mode_sel_i[1] + 1;
    for (int i = 0; i < cnt; i++) begin
      d = rnd() & 32'h1FF;
      @(negedge clk_i);
      if (i == 16) check(data_ready_o, 1'b0);
      data_buffer_reg_i = d[7:0];
      tx_ninth_bit_i = d[8];
      data_write_i = 1'b1;
      if (i < 16) exp_q.push_back(frame(d));
    end
    @(negedge clk_i);
    data_write_i = 1'b0;
    transmitter_on_i = 1'b1;
    wait_oe(1'b1);
    check(sync_clock_oe_o, sync_mode_i);
    transmitter_on_i = 1'b0;
    wait_oe(1'b0);
    for (int i = 0; exp_q.size() > 0; i++) begin
      check(line_receiver_model_i.word_q.pop_front(), exp_q.pop_front());
      g = line_receiver_model_i.gap_q.pop_front();
      if (i > 0) check(g, (nb + 1 + stop_bits_sel_i) * bc);
    end
    check(line_receiver_model_i.word_q.size(), 0);
    check({tx_complete_flag_o, tx_buffer_empty_flag_o, frame_error_flag_o}, 3'h6);
    tx_complete_clear_i = 1'b1;
    @(negedge clk_i);
    tx_complete_clear_i = 1'b0;
    check(tx_complete_flag_o, 1'b0);
    check(sync_clock_pin_o, clock_polarity_i);
  endtask : round
  // slave mode: a 48 ns link clock runs for 14 periods, on past the end of the frame
  task automatic slave();
    int d;
    int w;
    int idx;
    @(negedge clk_i);
    penable = 1'b0;
    sync_mode_i = 1'b1;
    sync_master_i = 1'b0;
    clock_polarity_i = 1'b0;
    char_size_sel_i = 3'h3;
    parity_mode_sel_i = 2'h0;
    stop_bits_sel_i = 1'b0;
    d = rnd() & 32'hFF;
    data_buffer_reg_i = d[7:0];
    data_write_i = 1'b1;
    @(negedge clk_i);
    data_write_i = 1'b0;
    transmitter_on_i = 1'b1;
    idx = -1;
    w = 0;
    repeat (14) begin
      #24 sync_clock_pin_i = 1'b1;
      #24;
      if (idx < 0 && serial_out_pin_o === 1'b0) idx = 0;
      else if (idx >= 0 && idx < 9) begin
        w[idx] = serial_out_pin_o;
        idx++;
      end
      sync_clock_pin_i = 1'b0;
    end
    check(w, frame(d));
    @(negedge clk_i);
    transmitter_on_i = 1'b0;
    wait_oe(1'b0);
  endtask : slave
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    // about four times the longest expected run, 80k clocks
    #400000;
    n_fail++;
    test_done();
  end
  initial begin
    {reset_i, penable} = 2'b11;
    {stop_bits_sel_i, double_speed_bit_i, sync_mode_i, sync_master_i} = 4'h0;
    {clock_polarity_i, transmitter_on_i, tx_ninth_bit_i, data_write_i} = 4'h0;
    {tx_complete_clear_i, sync_clock_pin_i} = 2'b00;
    char_size_sel_i = 3'h3;
    parity_mode_sel_i = 2'h0;
    baud_divisor_reg_i = 12'h000;
    data_buffer_reg_i = 8'h00;
    bc = 16;
    nb = 9;
    repeat (16) @(negedge clk_i);
    reset_i = 1'b0;
    for (int r = 0; r < 12; r++) round(r, r == 0 ? 17 : 3);
    slave();
    test_done();
  end
endmodule : usart_frame_transmitter_bench

// *** tb/usart_tx_monitor.sv ***
// port checker for the serial frame transmitter
`timescale 1ns/100ps
module usart_tx_monitor (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sync_mode_i,
  input wire logic transmitter_on_i,
  input wire logic data_write_i,
  input wire logic data_ready_o,
  input wire logic tx_buffer_empty_flag_o,
  input wire logic tx_complete_flag_o,
  input wire logic tx_complete_clear_i,
  input wire logic rx_first_stop_i,
  input wire logic rx_stop_strobe_i,
  input wire logic frame_error_flag_o,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_oe_o,
  input wire logic sync_clock_oe_o
);
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // a released line must rest at the idle level
  idle_line_a: assert property (!serial_out_oe_o |-> serial_out_pin_o)
    else $error("line low while released");
  write_fills_a: assert property (data_write_i && data_ready_o |=> !tx_buffer_empty_flag_o)
    else $error("empty flag kept after write");
  room_when_empty_a: assert property (tx_buffer_empty_flag_o |-> data_ready_o)
    else $error("no room although empty");
  done_sticky_a: assert property (tx_complete_flag_o && !tx_complete_clear_i |=> tx_complete_flag_o)
    else $error("complete flag lost");
  // clearing while idle cannot race a set
  done_clear_a: assert property (tx_complete_clear_i && !serial_out_oe_o |=> !tx_complete_flag_o)
    else $error("complete flag not cleared");
  frame_err_a: assert property (rx_stop_strobe_i |=> frame_error_flag_o == !$past(rx_first_stop_i))
    else $error("frame error flag wrong");
  pin_owner_a: assert property ($rose(serial_out_oe_o) |-> $past(transmitter_on_i))
    else $error("pin taken while disabled");
  drain_release_a: assert property (!transmitter_on_i && tx_buffer_empty_flag_o |-> ##[0:1000] !serial_out_oe_o)
    else $error("pin not released");
  // async bits last at least eight clocks even at double speed
  bit_length_a: assert property ($fell(serial_out_pin_o) && !sync_mode_i |-> !serial_out_pin_o [*8])
    else $error("low bit too short");
  clock_owner_a: assert property (!serial_out_oe_o |-> !sync_clock_oe_o)
    else $error("clock pin driven while idle");
  cover property ($rose(tx_complete_flag_o));
  cover property (!data_ready_o);
  cover property ($fell(serial_out_oe_o));
  cover property (sync_clock_oe_o && !serial_out_pin_o);
endmodule : usart_tx_monitor
bind usart_frame_transmitter usart_tx_monitor usart_tx_monitor_i (.clk_i(clk_i), .reset_i(reset_i),
  .sync_mode_i(sync_mode_i), .transmitter_on_i(transmitter_on_i), .data_write_i(data_write_i),
  .data_ready_o(data_ready_o), .tx_buffer_empty_flag_o(tx_buffer_empty_flag_o),
  .tx_complete_flag_o(tx_complete_flag_o), .tx_complete_clear_i(tx_complete_clear_i),
  .rx_first_stop_i(rx_first_stop_i), .rx_stop_strobe_i(rx_stop_strobe_i),
  .frame_error_flag_o(frame_error_flag_o), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_oe_o(serial_out_oe_o), .sync_clock_oe_o(sync_clock_oe_o));

// *** verilog/tx_char_fifo.sv ***
// small synchronous FIFO holding characters waiting for the shifter
`timescale 1ns/100ps
module tx_char_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // refuse shapes the pointer logic cannot serve
  initial begin
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("tx_char_fifo: DEPTH must be a power of two >= 2, WIDTH >= 1");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];   // storage words
  logic [AW-1:0]    wr_ptr;        // next slot to fill
  logic [AW-1:0]    rd_ptr;        // oldest word
  logic [AW:0]      count;         // words held
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  // storage write, no reset needed for data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule : tx_char_fifo

// *** verilog/usart_frame_transmitter.sv ***
// serial frame formatter and transmitter with character buffer and clock selection
`timescale 1ns/100ps
`include "usart_tx_defs.svh"
module usart_frame_transmitter #(
  parameter int DIV_W      = 12,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  // frame format, shared with the receiver
  input  wire usart_tx_pkg::char_size_t char_size_sel_i,
  input  wire logic [1:0]              parity_mode_sel_i,
  input  wire logic                    stop_bits_sel_i,
  // clocking
  input  wire logic [DIV_W-1:0]        baud_divisor_reg_i,
  input  wire logic                    double_speed_bit_i,
  input  wire logic                    sync_mode_i,
  input  wire logic                    sync_master_i,
  input  wire logic                    clock_polarity_i,
  // control
  input  wire logic                    transmitter_on_i,
  input  wire logic                    tx_ninth_bit_i,
  // data buffer write port
  input  wire logic [7:0]              data_buffer_reg_i,
  input  wire logic                    data_write_i,
  output logic                         data_ready_o,
  // status
  output logic                         tx_buffer_empty_flag_o,
  output logic                         tx_complete_flag_o,
  input  wire logic                    tx_complete_clear_i,
  // receiver stop-bit check
  input  wire logic                    rx_first_stop_i,
  input  wire logic                    rx_stop_strobe_i,
  output logic                         frame_error_flag_o,
  // pins
  output logic                         serial_out_pin_o,
  output logic                         serial_out_oe_o,
  input  wire logic                    sync_clock_pin_i,
  output logic                         sync_clock_pin_o,
  output logic                         sync_clock_oe_o
);

  import usart_tx_pkg::*;

  // refuse a divisor width the baud counter cannot hold
  initial begin
    if (DIV_W < 1 || DIV_W > 16) begin
      $error("usart_frame_transmitter: DIV_W must be 1..16");
    end
  end

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // number of data bits for a size code; reserved codes act as eight
  function automatic logic [3:0] data_bits(input char_size_t cs);
    logic [3:0] n;
    n = 4'h8;
    if (cs == `UTX_CS_9BIT) begin
      n = 4'h9;
    end else if (cs <= `UTX_CS_8BIT) begin
      n = 4'h5 + {2'b00, cs[1:0]};
    end
    return n;
  endfunction : data_bits

  // keep only the bits the character size uses
  function automatic logic [8:0] mask_char(input logic [8:0] d, input logic [3:0] n);
    logic [8:0] m;
    m = '0;
    for (int i = 0; i < `UTX_MAX_DATA; i++) begin
      if (i < n) begin
        m[i] = d[i];
      end
    end
    return m;
  endfunction : mask_char

  // parity over the used data bits, inverted for odd
  function automatic logic parity_of(input logic [8:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction : parity_of

  // total bits on the line for the current format
  function automatic logic [3:0] frame_len(input logic [3:0] n, input logic par,
                                           input logic two_stop);
    return 4'h2 + n + {3'b000, par} + {3'b000, two_stop};
  endfunction : frame_len

  // frame vector, bit 0 leaves the shifter first
  function automatic logic [`UTX_FRAME_W-1:0] build_frame(input logic [8:0] d,
                                                          input logic [3:0] n,
                                                          input logic par,
                                                          input logic odd);
    logic [`UTX_FRAME_W-1:0] f;
    f    = `UTX_RST_FRAME;
    f[0] = 1'b0;
    for (int i = 0; i < `UTX_MAX_DATA; i++) begin
      if (i < n) begin
        f[1+i] = d[i];
      end
    end
    if (par) begin
      f[1+n] = parity_of(d, odd);
    end
    return f;
  endfunction : build_frame

  // ---------------------------------------------------------------
  // format decode, also what the receiver sees
  // ---------------------------------------------------------------
  logic [3:0] fmt_bits;         // data bits per character
  logic       fmt_par;          // parity enabled
  logic       fmt_odd;          // odd parity selected
  logic [3:0] fmt_len;          // bits per frame

  assign fmt_bits = data_bits(char_size_sel_i);
  assign fmt_par  = parity_mode_sel_i[`UTX_PAR_EN_POS];
  assign fmt_odd  = parity_mode_sel_i[`UTX_PAR_ODD_POS];
  // stop select adds the second stop
  assign fmt_len  = frame_len(fmt_bits, fmt_par, stop_bits_sel_i);

  // ---------------------------------------------------------------
  // clock mode selection
  // ---------------------------------------------------------------
  clk_mode_t mode;              // current transmitter clock mode

  // combinational mode decode; double speed only matters when async
  always_comb begin
    if (sync_mode_i) begin
      mode = sync_master_i ? MODE_SYNC_MASTER : MODE_SYNC_SLAVE;
    end else begin
      mode = double_speed_bit_i ? MODE_ASYNC_DOUBLE : MODE_ASYNC_NORMAL;
    end
  end

  // ---------------------------------------------------------------
  // transmit buffer
  // ---------------------------------------------------------------
  logic [8:0] wr_word;          // ninth bit and low byte
  logic [8:0] buf_word;         // oldest waiting character
  logic       buf_valid;        // buffer holds a character
  logic       buf_pop;          // shifter takes a character

  // ninth bit must already be set when the low byte arrives
  assign wr_word = {tx_ninth_bit_i, data_buffer_reg_i};

  // a write of the data buffer queues a character
  tx_char_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_data_i   (wr_word),
    .in_valid_i  (data_write_i),
    .in_ready_o  (data_ready_o),
    .out_data_o  (buf_word),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop)
  );

  // empty flag straight from the buffer level
  assign tx_buffer_empty_flag_o = !buf_valid;

  // ---------------------------------------------------------------
  // enable with drain: stays active until all data has left
  // ---------------------------------------------------------------
  logic         active;         // transmitter owns the pins
  shift_state_t state;          // shifter state

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      active <= 1'b0;
    end else if (transmitter_on_i) begin
      active <= 1'b1;
    end else if (state == SHIFT_IDLE && !buf_valid) begin
      active <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // external clock pin synchroniser, three stages
  // ---------------------------------------------------------------
  logic xck_meta;               // first stage, only feeds the second
  logic xck_s2;                 // second stage
  logic xck_s3;                 // third stage, edge reference

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      xck_meta <= 1'b0;
      xck_s2   <= 1'b0;
      xck_s3   <= 1'b0;
    end else begin
      xck_meta <= sync_clock_pin_i;
      xck_s2   <= xck_meta;
      xck_s3   <= xck_s2;
    end
  end

  // a change counts while the second stage has it and the third does not yet
  logic ext_rise;               // external rising edge seen
  logic ext_fall;               // external falling edge seen

  assign ext_rise = xck_s2 && !xck_s3;
  assign ext_fall = !xck_s2 && xck_s3;

  // ---------------------------------------------------------------
  // baud generator: down-counter reloaded with the divisor
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt;    // counts system clocks per baud tick
  logic             baud_tick;  // one pulse per divisor period

  assign baud_tick = (div_cnt == '0);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_cnt <= DIV_W'(`UTX_RST_DIVCNT);
    end else if (baud_tick) begin
      div_cnt <= baud_divisor_reg_i;
    end else begin
      div_cnt <= div_cnt - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // async prescaler: 16 ticks normal, 8 ticks double speed
  // ---------------------------------------------------------------
  logic [4:0] presc;            // baud ticks within one bit
  logic [4:0] presc_top;        // last prescaler value for the mode

  assign presc_top = (mode == MODE_ASYNC_DOUBLE) ? (`UTX_DIV_DOUBLE - 5'h01)
                                                 : (`UTX_DIV_NORMAL - 5'h01);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      presc <= `UTX_RST_PRESC;
    end else if (baud_tick) begin
      // restart early if the mode shrinks the period under the count
      presc <= (presc >= presc_top) ? 5'h00 : presc + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // master synchronous clock output: toggles on every baud tick
  // ---------------------------------------------------------------
  logic xck_out;                // generated clock level

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      xck_out <= 1'b0;
    end else if (mode == MODE_SYNC_MASTER && active) begin
      if (baud_tick) begin
        xck_out <= !xck_out;
      end
    end else begin
      // idle at the level that precedes the change edge
      xck_out <= clock_polarity_i;
    end
  end

  assign sync_clock_pin_o = xck_out;
  // pin is taken over only in master synchronous mode
  assign sync_clock_oe_o  = active && (mode == MODE_SYNC_MASTER);

  // ---------------------------------------------------------------
  // bit tick: the moment the line may change
  // ---------------------------------------------------------------
  logic bit_tick;               // start of a new bit period

  // polarity zero changes data on the rising clock edge
  always_comb begin
    unique case (mode)
      MODE_ASYNC_NORMAL,
      MODE_ASYNC_DOUBLE: bit_tick = baud_tick && (presc == presc_top);
      MODE_SYNC_MASTER:  bit_tick = baud_tick && (xck_out == clock_polarity_i);
      MODE_SYNC_SLAVE:   bit_tick = clock_polarity_i ? ext_fall : ext_rise;
    endcase
  end

  // ---------------------------------------------------------------
  // shifter
  // ---------------------------------------------------------------
  logic [`UTX_FRAME_W-1:0] shifter;   // bit 0 is on the line
  logic [`UTX_CNT_W-1:0]   remaining; // bits left including current
  logic                    last_bit;  // current bit is the final stop
  logic                    take;      // load a new frame this tick
  logic [8:0]              load_data; // character trimmed to size

  assign last_bit  = (state == SHIFT_BUSY) && (remaining == 4'h1);
  // unused high bits of the written byte never reach the line
  assign load_data = mask_char(buf_word, fmt_bits);
  // idle shifter, or the tick that ends the last stop bit
  assign take      = bit_tick && active && buf_valid &&
                     (state == SHIFT_IDLE || last_bit);
  assign buf_pop   = take;

  // shifter state machine
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= SHIFT_IDLE;
    end else begin
      unique case (state)
        SHIFT_IDLE: begin
          if (take) begin
            state <= SHIFT_BUSY;
          end
        end
        SHIFT_BUSY: begin
          if (bit_tick && last_bit && !take) begin
            state <= SHIFT_IDLE;
          end
        end
      endcase
    end
  end

  // frame contents and bit count
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      shifter   <= `UTX_RST_FRAME;
      remaining <= '0;
    end else if (take) begin
      // back-to-back: the new start bit follows the stop directly
      shifter   <= build_frame(load_data, fmt_bits, fmt_par, fmt_odd);
      remaining <= fmt_len;
    end else if (bit_tick && state == SHIFT_BUSY) begin
      // ones shift in so the line rests high after the frame
      shifter   <= {1'b1, shifter[`UTX_FRAME_W-1:1]};
      remaining <= remaining - 4'h1;
    end
  end

  // line level comes straight from the shifter flop
  assign serial_out_pin_o = shifter[0];
  // port logic gets the pin back only after the drain completes
  assign serial_out_oe_o  = active;

  // ---------------------------------------------------------------
  // transmit complete flag
  // ---------------------------------------------------------------
  logic done_evt;               // frame ended with nothing waiting

  assign done_evt = bit_tick && last_bit && !take && !buf_valid;

  // a completion in the clearing cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_complete_flag_o <= 1'b0;
    end else if (done_evt) begin
      tx_complete_flag_o <= 1'b1;
    end else if (tx_complete_clear_i) begin
      tx_complete_flag_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // receiver stop check: only the first stop bit is judged
  // ---------------------------------------------------------------
  // the receiver works from the same decoded format as above
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      frame_error_flag_o <= 1'b0;
    end else if (rx_stop_strobe_i) begin
      frame_error_flag_o <= !rx_first_stop_i;
    end
  end

endmodule : usart_frame_transmitter

// *** verilog/usart_tx_defs.svh ***
// constants for the serial frame transmitter: codes, field positions, divisors, reset values
`ifndef USART_TX_DEFS_SVH
`define USART_TX_DEFS_SVH

// longest frame: start + 9 data + parity + 2 stops
`define UTX_FRAME_W        13
`define UTX_CNT_W          4
`define UTX_MAX_DATA       9

// character size codes (three-bit field)
`define UTX_CS_5BIT        3'h0
`define UTX_CS_6BIT        3'h1
`define UTX_CS_7BIT        3'h2
`define UTX_CS_8BIT        3'h3
`define UTX_CS_9BIT        3'h7

// parity mode field positions
`define UTX_PAR_EN_POS     1
`define UTX_PAR_ODD_POS    0

// transmitter clock divisors applied to the baud tick
`define UTX_DIV_NORMAL     5'h10
`define UTX_DIV_DOUBLE     5'h08

// reset values
`define UTX_RST_DIVCNT     12'h000
`define UTX_RST_PRESC      5'h00
`define UTX_RST_FRAME      13'h1FFF

`endif

// *** verilog/usart_tx_pkg.sv ***
// types shared by the serial frame transmitter and its bench
package usart_tx_pkg;

  // transmitter clocking modes
  typedef enum logic [1:0] {
    MODE_ASYNC_NORMAL = 2'b00,
    MODE_ASYNC_DOUBLE = 2'b01,
    MODE_SYNC_MASTER  = 2'b10,
    MODE_SYNC_SLAVE   = 2'b11
  } clk_mode_t;

  // shifter states
  typedef enum logic [0:0] {
    SHIFT_IDLE = 1'b0,
    SHIFT_BUSY = 1'b1
  } shift_state_t;

  // three-bit character size code
  typedef logic [2:0] char_size_t;

endpackage : usart_tx_pkg
